// >>> rtl/ccp_pkg.sv
// shared constants and types of the custom coprocessor port controller
package ccp_pkg;

	// register byte offsets on the control bus
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_LAT  = 12'h004;
	localparam logic [11:0] REG_STAT = 12'h008;
	localparam logic [11:0] REG_DONE = 12'h00C;

	// reset values and field positions
	localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
	localparam logic [31:0] LAT_RST       = 32'h0000_0004;
	localparam int          CTRL_EN_BIT   = 0;
	localparam int          STAT_BUSY_BIT = 1;
	localparam int          STAT_HOLD_BIT = 2;
	localparam int          LAT_W         = 16;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// instruction word fields used by the engine
	localparam int OP_LSB    = 12;
	localparam int STORE_BIT = 12;
	localparam int SLOW_BIT  = 14;
	localparam int SIZE_LSB  = 25;
	localparam int MEM_BIT   = 27;
	localparam int FPU_BIT   = 30;

	// operation and access size codes
	localparam logic [1:0] OP_ADD  = 2'h0;
	localparam logic [1:0] OP_SUB  = 2'h1;
	localparam logic [1:0] OP_XOR  = 2'h2;
	localparam logic [1:0] OP_MAC  = 2'h3;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] SZ_RSVD = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_EXEC,
		ST_MCMD,
		ST_MRSP,
		ST_SLOW,
		ST_VWB
	} ccp_state_t;

	// natural alignment check, reserved size counts as bad
	function automatic logic ccp_aligned(input logic [1:0] lo, input logic [1:0] sz);
		case (sz)
			SZ_BYTE: ccp_aligned = 1'b1;
			SZ_HALF: ccp_aligned = (lo[0] == 1'b0);
			SZ_WORD: ccp_aligned = (lo == 2'h0);
			default: ccp_aligned = 1'b0;
		endcase
	endfunction

endpackage

// >>> rtl/ccp_alu.sv
// combinational arithmetic unit of the coprocessor engine
`timescale 1ns/10ps
`default_nettype none
module ccp_alu #(
	parameter int W = 64
) (
	input  wire logic [1:0]   op,
	input  wire logic [W-1:0] a,
	input  wire logic [W-1:0] b,
	input  wire logic [W-1:0] c,
	output logic      [W-1:0] y
);
	// c is the accumulator operand of multiply-accumulate
	always_comb begin
		case (op)
			ccp_pkg::OP_ADD: y = a + b;
			ccp_pkg::OP_SUB: y = a - b;
			ccp_pkg::OP_XOR: y = a ^ b;
			default:         y = (a * b) + c; // product kept to W bits
		endcase
	end
endmodule // ccp_alu
`default_nettype wire

// >>> rtl/ccp_axil_regs.sv
// AXI4-Lite register slave of the coprocessor port controller
`timescale 1ns/10ps
`default_nettype none
module ccp_axil_regs (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        stat_busy,
	input  wire logic        stat_hold,
	input  wire logic [31:0] done_cnt,
	output logic             ctrl_en,
	output logic [15:0]      lat_cfg
);
	typedef struct packed {
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [31:0] ctrl;
		logic [31:0] lat;
	} ccp_regs_t;

	ccp_regs_t q;
	ccp_regs_t next_q;
	logic      wr_go;
	logic      rd_go;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				old[8*i +: 8] = nw[8*i +: 8];
			end
		end
		merge = old;
	endfunction

	// aw and w taken together, one write outstanding
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
	assign rd_go         = s_axi_arvalid && !q.rvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rresp   = q.rresp;
	assign s_axi_rdata   = q.rdata;
	assign ctrl_en       = q.ctrl[ccp_pkg::CTRL_EN_BIT];
	assign lat_cfg       = q.lat[15:0];

	// anything outside the four words answers SLVERR
	always_comb begin
		next_q = q;
		if (q.bvalid && s_axi_bready) begin
			next_q.bvalid = 1'b0;
		end
		if (q.rvalid && s_axi_rready) begin
			next_q.rvalid = 1'b0;
		end
		if (wr_go) begin
			next_q.bvalid = 1'b1;
			next_q.bresp  = ccp_pkg::RESP_OKAY;
			case (s_axi_awaddr[11:0])
				ccp_pkg::REG_CTRL: next_q.ctrl = merge(q.ctrl, s_axi_wdata, s_axi_wstrb) & 32'h1;
				ccp_pkg::REG_LAT:  next_q.lat  = merge(q.lat, s_axi_wdata, s_axi_wstrb) & 32'hFFFF;
				ccp_pkg::REG_STAT, ccp_pkg::REG_DONE: ; // read only, write ignored
				default: next_q.bresp = ccp_pkg::RESP_SLVERR;
			endcase
			if (s_axi_awaddr[31:12] != 20'h0) begin
				next_q.bresp = ccp_pkg::RESP_SLVERR;
			end
		end
		if (rd_go) begin
			next_q.rvalid = 1'b1;
			next_q.rresp  = ccp_pkg::RESP_OKAY;
			case (s_axi_araddr[11:0])
				ccp_pkg::REG_CTRL: next_q.rdata = q.ctrl;
				ccp_pkg::REG_LAT:  next_q.rdata = q.lat;
				ccp_pkg::REG_STAT: next_q.rdata = {29'h0, stat_hold, stat_busy, q.ctrl[0]};
				ccp_pkg::REG_DONE: next_q.rdata = done_cnt;
				default: begin
					next_q.rdata = 32'h0;
					next_q.rresp = ccp_pkg::RESP_SLVERR;
				end
			endcase
			if (s_axi_araddr[31:12] != 20'h0) begin
				next_q.rdata = 32'h0;
				next_q.rresp = ccp_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q      <= '0;
			q.ctrl <= ccp_pkg::CTRL_RST;
			q.lat  <= ccp_pkg::LAT_RST;
		end else begin
			q <= next_q;
		end
	end
endmodule // ccp_axil_regs
`default_nettype wire

// >>> rtl/ccp_host_top.sv
// coprocessor end of the custom instruction port, steered over AXI4-Lite
// Contract
// - fast flag means result in the same cycle.
// - fast result at core width, high half in pair option.
// - slow valid held until the core's ready.
// - slow result held until the core's ready.
// - memory commands only in slow instructions; valid held to ready.
// - command address and write data held until accepted.
// - direction bit: zero write, one read; held until accepted.
// - sizes byte, half, word, reserved; natural alignment only.
// - commands carry privileges, held until taken.
// - hold rises a cycle after memory instruction, falls when done.
// - vector result by valid/ready with saturation and fp flags.
// - blocking mode keeps ready low until transfer ends.
// - command machine privilege matches starting request.
`timescale 1ns/10ps
`default_nettype none
module ccp_host_top #(
	parameter int XLEN    = 32,
	parameter bit PAIR_EN = 1'b1,
	parameter int LSUW    = 32,
	parameter int VLEN    = 128
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [31:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [31:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              cop_req_vld,
	output logic                   cop_req_rdy,
	input  wire logic [31:0]       cop_req_opcode_word,
	input  wire logic [XLEN-1:0]   cop_req_src1,
	input  wire logic [XLEN-1:0]   cop_req_src2,
	input  wire logic [XLEN-1:0]   cop_req_src3,
	input  wire logic [31:0]       cop_req_src1_hi,
	input  wire logic [31:0]       cop_req_src2_hi,
	input  wire logic [31:0]       cop_req_src3_hi,
	input  wire logic              cop_req_machine_priv,
	input  wire logic              cop_req_super_priv,
	output logic                   cop_fast_rsp_flag,
	output logic [XLEN-1:0]        cop_fast_rsp_result,
	output logic [31:0]            cop_fast_rsp_result_hi,
	output logic                   cop_fast_rsp_fault,
	output logic                   cop_slow_rsp_vld,
	input  wire logic              cop_slow_rsp_rdy,
	output logic [XLEN-1:0]        cop_slow_rsp_result,
	output logic                   cop_slow_rsp_fault,
	output logic                   cop_mem_cmd_vld,
	input  wire logic              cop_mem_cmd_rdy,
	output logic [XLEN-1:0]        cop_mem_cmd_addr,
	output logic                   cop_mem_cmd_is_read,
	output logic [LSUW-1:0]        cop_mem_cmd_wdata,
	output logic [1:0]             cop_mem_cmd_size,
	output logic                   cop_mem_cmd_machine_priv,
	output logic                   cop_mem_cmd_super_priv,
	output logic                   cop_lsu_hold,
	input  wire logic              cop_mem_rsp_vld,
	output logic                   cop_mem_rsp_rdy,
	input  wire logic [LSUW-1:0]   cop_mem_rsp_rdata,
	input  wire logic              cop_mem_rsp_err,
	input  wire logic              vec_cop_req_vld,
	output logic                   vec_cop_req_rdy,
	input  wire logic [31:0]       vec_cop_req_opcode_word,
	input  wire logic [1:0]        vec_cop_beat_pos,
	input  wire logic [VLEN/8-1:0] vec_cop_elem_mask,
	input  wire logic [VLEN-1:0]   vec_cop_src_a,
	input  wire logic [VLEN-1:0]   vec_cop_src_b,
	input  wire logic [VLEN-1:0]   vec_cop_src_acc,
	output logic                   vec_cop_wb_vld,
	input  wire logic              vec_cop_wb_rdy,
	output logic [VLEN-1:0]        vec_cop_wb_data,
	output logic                   vec_cop_wb_vxsat,
	output logic                   vec_cop_wb_fflag
);
	// pair high half sits above the core-width value
	localparam int XW = XLEN + 32;

	typedef struct packed {
		ccp_pkg::ccp_state_t st;
		logic [31:0]         instr;
		logic [XW-1:0]       a;
		logic [XW-1:0]       b;
		logic [XW-1:0]       c;
		logic                mprv;
		logic                sprv;
		logic [15:0]         cnt;
		logic [XW-1:0]       res;
		logic                fault;
		logic                hold;
		logic [VLEN-1:0]     vres;
		logic                vsat;
		logic                vff;
		logic [31:0]         done;
	} ccp_core_t;

	ccp_core_t     q;
	ccp_core_t     next_q;
	logic          ctrl_en;
	logic [15:0]   lat_cfg;
	logic          req_hs;
	logic          vec_hs;
	logic          idle;
	logic [XW-1:0] live_a;
	logic [XW-1:0] live_b;
	logic [XW-1:0] live_c;
	logic [XW-1:0] alu_a;
	logic [XW-1:0] alu_b;
	logic [XW-1:0] alu_c;
	logic [1:0]    alu_op;
	logic [XW-1:0] alu_y;
	logic [VLEN:0] vsum;
	logic          req_slow;
	logic          req_mem;
	logic          req_ok;

	ccp_axil_regs u_regs (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.stat_busy     (!idle),
		.stat_hold     (q.hold),
		.done_cnt      (q.done),
		.ctrl_en       (ctrl_en),
		.lat_cfg       (lat_cfg)
	);

	// pair halves are zero when the pair option is off
	assign live_a = {PAIR_EN ? cop_req_src1_hi : 32'h0, cop_req_src1};
	assign live_b = {PAIR_EN ? cop_req_src2_hi : 32'h0, cop_req_src2};
	assign live_c = {PAIR_EN ? cop_req_src3_hi : 32'h0, cop_req_src3};

	// one alu: live operands when idle, latched ones when busy
	assign idle   = (q.st == ccp_pkg::ST_IDLE);
	assign alu_a  = idle ? live_a : q.a;
	assign alu_b  = idle ? live_b : q.b;
	assign alu_c  = idle ? live_c : q.c;
	assign alu_op = idle ? cop_req_opcode_word[ccp_pkg::OP_LSB +: 2] : q.instr[ccp_pkg::OP_LSB +: 2];

	ccp_alu #(
		.W (XW)
	) u_alu (
		.op (alu_op),
		.a  (alu_a),
		.b  (alu_b),
		.c  (alu_c),
		.y  (alu_y)
	);

	// request classification
	assign req_slow = cop_req_opcode_word[ccp_pkg::SLOW_BIT];
	assign req_mem  = cop_req_opcode_word[ccp_pkg::MEM_BIT];
	assign req_ok   = ccp_pkg::ccp_aligned(cop_req_src1[1:0],
	                                       cop_req_opcode_word[ccp_pkg::SIZE_LSB +: 2]);

	// blocking mode: ready only while idle and enabled by software
	assign cop_req_rdy = ctrl_en && idle;
	assign req_hs      = cop_req_vld && cop_req_rdy;
	// scalar requests win when both arrive together
	assign vec_cop_req_rdy = ctrl_en && idle && !cop_req_vld;
	assign vec_hs          = vec_cop_req_vld && vec_cop_req_rdy;
	assign vsum            = {1'b0, vec_cop_src_a} + {1'b0, vec_cop_src_b};

	// same-cycle answer in the accepting cycle; fpu type faults
	assign cop_fast_rsp_flag      = req_hs && !req_slow;
	assign cop_fast_rsp_result    = alu_y[XLEN-1:0];
	assign cop_fast_rsp_result_hi = alu_y[XW-1:XLEN];
	assign cop_fast_rsp_fault     = cop_fast_rsp_flag && cop_req_opcode_word[ccp_pkg::FPU_BIT];

	// slow response held from state until the core takes it
	assign cop_slow_rsp_vld    = (q.st == ccp_pkg::ST_SLOW);
	assign cop_slow_rsp_result = q.res[XLEN-1:0];
	assign cop_slow_rsp_fault  = q.fault;

	// command fields latched at acceptance
	assign cop_mem_cmd_vld          = (q.st == ccp_pkg::ST_MCMD);
	assign cop_mem_cmd_addr         = q.a[XLEN-1:0];
	assign cop_mem_cmd_wdata        = q.b[LSUW-1:0];
	assign cop_mem_cmd_is_read      = !q.instr[ccp_pkg::STORE_BIT];
	assign cop_mem_cmd_size         = q.instr[ccp_pkg::SIZE_LSB +: 2];
	assign cop_mem_cmd_machine_priv = q.mprv;
	assign cop_mem_cmd_super_priv   = q.sprv;
	assign cop_lsu_hold             = q.hold;
	// one command outstanding, so responses pair with commands in order
	assign cop_mem_rsp_rdy          = (q.st == ccp_pkg::ST_MRSP);

	assign vec_cop_wb_vld   = (q.st == ccp_pkg::ST_VWB);
	assign vec_cop_wb_data  = q.vres;
	assign vec_cop_wb_vxsat = q.vsat;
	assign vec_cop_wb_fflag = q.vff;

	// engine sequencing
	always_comb begin
		next_q = q;
		case (q.st)
			ccp_pkg::ST_IDLE: begin
				if (req_hs) begin
					next_q.instr = cop_req_opcode_word;
					next_q.a     = live_a;
					next_q.b     = live_b;
					next_q.c     = live_c;
					next_q.mprv  = cop_req_machine_priv;
					next_q.sprv  = cop_req_super_priv;
					next_q.fault = cop_req_opcode_word[ccp_pkg::FPU_BIT];
					if (!req_slow) begin
						next_q.done = q.done + 32'h1;
					end else if (!req_mem) begin
						next_q.st  = ccp_pkg::ST_EXEC;
						next_q.cnt = lat_cfg;
					end else if (!req_ok) begin
						// bad size or alignment: fault at once, no access
						next_q.st    = ccp_pkg::ST_SLOW;
						next_q.res   = '0;
						next_q.fault = 1'b1;
					end else begin
						next_q.st   = ccp_pkg::ST_MCMD;
						next_q.hold = 1'b1;
					end
				end else if (vec_hs) begin
					next_q.vres = vsum[VLEN-1:0];
					next_q.vsat = vsum[VLEN];
					next_q.vff  = vec_cop_req_opcode_word[ccp_pkg::FPU_BIT];
					next_q.st   = ccp_pkg::ST_VWB;
				end
			end
			ccp_pkg::ST_EXEC: begin
				// register latency models a long computation
				if (q.cnt == 16'h0) begin
					next_q.res = alu_y;
					next_q.st  = ccp_pkg::ST_SLOW;
				end else begin
					next_q.cnt = q.cnt - 16'h1;
				end
			end
			ccp_pkg::ST_MCMD: begin
				if (cop_mem_cmd_rdy) begin
					next_q.st = ccp_pkg::ST_MRSP;
				end
			end
			ccp_pkg::ST_MRSP: begin
				if (cop_mem_rsp_vld) begin
					next_q.res   = cop_mem_cmd_is_read ? XW'(cop_mem_rsp_rdata) : '0;
					next_q.fault = q.fault || cop_mem_rsp_err;
					next_q.hold  = 1'b0;
					next_q.st    = ccp_pkg::ST_SLOW;
				end
			end
			ccp_pkg::ST_SLOW: begin
				if (cop_slow_rsp_rdy) begin
					next_q.st    = ccp_pkg::ST_IDLE;
					next_q.fault = 1'b0;
					next_q.done  = q.done + 32'h1;
				end
			end
			ccp_pkg::ST_VWB: begin
				if (vec_cop_wb_rdy) begin
					next_q.st   = ccp_pkg::ST_IDLE;
					next_q.done = q.done + 32'h1;
				end
			end
			default: next_q.st = ccp_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	default clocking ccp_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_FAST_SAME: assert property (
		cop_fast_rsp_flag |-> cop_req_vld && cop_req_rdy && !req_slow)
		else $error("fast flag misplaced");
	AST_REQ_BLOCK: assert property (
		req_hs && req_slow |=> !cop_req_rdy)
		else $error("ready stayed high");
	AST_SLOW_HOLD: assert property (
		cop_slow_rsp_vld && !cop_slow_rsp_rdy |=> cop_slow_rsp_vld)
		else $error("slow valid dropped");
	AST_SLOW_DATA: assert property (
		cop_slow_rsp_vld && !cop_slow_rsp_rdy |=> $stable(cop_slow_rsp_result)
		&& $stable(cop_slow_rsp_fault))
		else $error("slow result moved");
	AST_MEM_IN_SLOW: assert property (
		cop_mem_cmd_vld |-> !cop_req_rdy && cop_lsu_hold && !cop_slow_rsp_vld)
		else $error("stray memory command");
	AST_MEM_STABLE: assert property (
		cop_mem_cmd_vld && !cop_mem_cmd_rdy |=> cop_mem_cmd_vld && $stable(cop_mem_cmd_addr)
		&& $stable(cop_mem_cmd_wdata) && $stable(cop_mem_cmd_is_read))
		else $error("memory command moved");
	AST_MEM_SIZE: assert property (
		cop_mem_cmd_vld |-> cop_mem_cmd_size != ccp_pkg::SZ_RSVD
		&& ccp_pkg::ccp_aligned(cop_mem_cmd_addr[1:0], cop_mem_cmd_size))
		else $error("bad command size");
	AST_MEM_START: assert property (
		req_hs && req_slow && req_mem && req_ok |=> cop_lsu_hold && cop_mem_cmd_vld
		&& cop_mem_cmd_machine_priv == $past(cop_req_machine_priv))
		else $error("bad memory start");
	AST_HOLD_CLR: assert property (
		cop_mem_rsp_vld && cop_mem_rsp_rdy |=> !cop_lsu_hold && cop_slow_rsp_vld)
		else $error("hold not cleared");
	AST_VEC_WB: assert property (
		vec_cop_wb_vld && !vec_cop_wb_rdy |=> vec_cop_wb_vld && $stable(vec_cop_wb_data))
		else $error("vector result dropped");
endmodule // ccp_host_top
`default_nettype wire

// >>> verif/ccp_core_mem.sv
// memory side of the master core model facing the coprocessor port
`timescale 1ns/10ps
`default_nettype none
module ccp_core_mem (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        err_req,
	input  wire logic        cop_mem_cmd_vld,
	output logic             cop_mem_cmd_rdy,
	input  wire logic [31:0] cop_mem_cmd_addr,
	input  wire logic        cop_mem_cmd_is_read,
	input  wire logic [31:0] cop_mem_cmd_wdata,
	output logic             cop_mem_rsp_vld,
	input  wire logic        cop_mem_rsp_rdy,
	output logic [31:0]      cop_mem_rsp_rdata,
	output logic             cop_mem_rsp_err,
	output logic [31:0]      last_wdata
);
	// ready a cycle late on purpose: command must be held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cop_mem_cmd_rdy <= 1'h0;
			cop_mem_rsp_vld <= 1'h0;
			cop_mem_rsp_rdata <= 32'h0;
			cop_mem_rsp_err <= 1'h0;
			last_wdata <= 32'h0;
		end else if (cop_mem_rsp_vld) begin
			// released data flips: stale word never looks fresh
			if (cop_mem_rsp_rdy) begin
				cop_mem_rsp_vld <= 1'h0;
				cop_mem_rsp_rdata <= ~cop_mem_rsp_rdata;
			end
		end else if (cop_mem_cmd_vld && cop_mem_cmd_rdy) begin
			cop_mem_cmd_rdy <= 1'h0;
			cop_mem_rsp_vld <= 1'h1;
			cop_mem_rsp_rdata <= cop_mem_cmd_addr ^ 32'h5A5A_0000;
			cop_mem_rsp_err <= err_req;
			if (!cop_mem_cmd_is_read) last_wdata <= cop_mem_cmd_wdata;
		end else begin
			cop_mem_cmd_rdy <= cop_mem_cmd_vld;
		end
	end
endmodule // ccp_core_mem
`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench of the coprocessor port controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam logic [63:0] A = 64'h1234_5678_9ABC_DEF0;
	localparam logic [63:0] B = 64'h0000_0002_0000_0003;
	localparam logic [63:0] C = 64'h0000_0011_0000_0022;
	localparam logic [31:0] MADR [5] = '{32'h100, 32'h102, 32'h101, 32'h104, 32'h108};
	localparam logic [1:0]  MSZ [5] = '{2'h2, 2'h1, 2'h2, 2'h3, 2'h2};
	logic         aclk, aresetn, mem_err_req, f;
	logic [31:0]  s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, last_wdata, rd, r, rh;
	logic [1:0]   s_axi_bresp, s_axi_rresp, resp;
	logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic         cop_req_vld, cop_req_rdy, cop_req_machine_priv, cop_req_super_priv;
	logic [31:0]  cop_req_opcode_word, cop_req_src1, cop_req_src2, cop_req_src3;
	logic [31:0]  cop_req_src1_hi, cop_req_src2_hi, cop_req_src3_hi, cop_slow_rsp_result;
	logic [31:0]  cop_fast_rsp_result, cop_fast_rsp_result_hi, vec_cop_req_opcode_word;
	logic         cop_fast_rsp_flag, cop_fast_rsp_fault, cop_slow_rsp_vld, cop_slow_rsp_rdy;
	logic         cop_slow_rsp_fault, cop_mem_cmd_vld, cop_mem_cmd_rdy, cop_mem_cmd_is_read;
	logic [31:0]  cop_mem_cmd_addr, cop_mem_cmd_wdata, cop_mem_rsp_rdata;
	logic         cop_mem_rsp_vld, cop_mem_rsp_rdy, cop_mem_rsp_err, vec_cop_req_vld;
	logic         vec_cop_req_rdy, vec_cop_wb_vld, vec_cop_wb_rdy, vec_cop_wb_vxsat, vec_cop_wb_fflag;
	logic [127:0] vec_cop_src_a, vec_cop_src_b, vec_cop_wb_data;
	logic [128:0] vsum;
	logic [63:0]  x;
	int           errors, num_checks, i, n;

	// single-beat, all-active vector group
	ccp_host_top i_ccp_host_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .cop_req_vld, .cop_req_rdy, .cop_req_opcode_word,
		.cop_req_src1, .cop_req_src2, .cop_req_src3, .cop_req_src1_hi, .cop_req_src2_hi,
		.cop_req_src3_hi, .cop_req_machine_priv, .cop_req_super_priv, .cop_fast_rsp_flag,
		.cop_fast_rsp_result, .cop_fast_rsp_result_hi, .cop_fast_rsp_fault, .cop_slow_rsp_vld,
		.cop_slow_rsp_rdy, .cop_slow_rsp_result, .cop_slow_rsp_fault, .cop_mem_cmd_vld,
		.cop_mem_cmd_rdy, .cop_mem_cmd_addr, .cop_mem_cmd_is_read, .cop_mem_cmd_wdata,
		.cop_mem_cmd_size(), .cop_mem_cmd_machine_priv(), .cop_mem_cmd_super_priv(),
		.cop_lsu_hold(), .cop_mem_rsp_vld, .cop_mem_rsp_rdy, .cop_mem_rsp_rdata, .cop_mem_rsp_err,
		.vec_cop_req_vld, .vec_cop_req_rdy, .vec_cop_req_opcode_word,
		.vec_cop_beat_pos(2'h3),
		.vec_cop_elem_mask(16'hFFFF),
		.vec_cop_src_a, .vec_cop_src_b, .vec_cop_src_acc(128'h0), .vec_cop_wb_vld,
		.vec_cop_wb_rdy, .vec_cop_wb_data, .vec_cop_wb_vxsat, .vec_cop_wb_fflag);

	ccp_core_mem i_ccp_core_mem (.aclk, .aresetn, .err_req(mem_err_req), .cop_mem_cmd_vld,
		.cop_mem_cmd_rdy, .cop_mem_cmd_addr, .cop_mem_cmd_is_read, .cop_mem_cmd_wdata,
		.cop_mem_rsp_vld, .cop_mem_rsp_rdy, .cop_mem_rsp_rdata, .cop_mem_rsp_err, .last_wdata);

	// free-running 50 MHz clock
	initial begin
		aclk = 1'h0;
		forever #10 aclk = ~aclk;
	end

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic tmo();
		errors++;
		$display("Error wait expired at %0t", $time);
		tally_and_finish();
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// spare edge at end: strobes never re-raised in one step
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do @(posedge aclk); while (s_axi_awready !== 1'h1 && ++n < 100);
		{s_axi_awvalid, s_axi_wvalid} <= 2'h0;
		do @(posedge aclk); while (s_axi_bvalid !== 1'h1 && ++n < 100);
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
		@(posedge aclk);
		if (n >= 100) tmo();
	endtask

	task automatic axi_rd(input logic [31:0] a);
		n = 0;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge aclk); while (s_axi_arready !== 1'h1 && ++n < 100);
		s_axi_arvalid <= 1'h0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'h1 && ++n < 100);
		{resp, rd} = {s_axi_rresp, s_axi_rdata};
		s_axi_rready <= 1'h0;
		@(posedge aclk);
		if (n >= 100) tmo();
	endtask

	// scalar request; fast answer taken at accepting edge, valid left up only after a fast answer
	task automatic issue(input logic [31:0] ins, input logic [63:0] a, b, c);
		n = 0;
		cop_req_opcode_word <= ins;
		{cop_req_src1_hi, cop_req_src1, cop_req_src2_hi, cop_req_src2} <= {a, b};
		{cop_req_src3_hi, cop_req_src3} <= c;
		cop_req_vld <= 1'h1;
		do @(posedge aclk); while (cop_req_rdy !== 1'h1 && ++n < 200);
		{r, rh, f} = {cop_fast_rsp_result, cop_fast_rsp_result_hi, cop_fast_rsp_fault};
		if (cop_fast_rsp_flag !== 1'h1) begin
			cop_req_vld <= 1'h0;
			do @(posedge aclk); while (cop_slow_rsp_vld !== 1'h1 && ++n < 200);
			cop_slow_rsp_rdy <= 1'h1;
			@(posedge aclk);
			{r, f} = {cop_slow_rsp_result, cop_slow_rsp_fault};
			cop_slow_rsp_rdy <= 1'h0;
			@(posedge aclk);
		end
		if (n >= 200) tmo();
	endtask

	// registers, fast, slow, memory, vector
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{cop_req_vld, cop_slow_rsp_rdy, vec_cop_req_vld, vec_cop_wb_rdy, mem_err_req} = '0;
		{cop_req_machine_priv, cop_req_super_priv, aresetn, errors, num_checks} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, cop_req_opcode_word} = '0;
		{cop_req_src1, cop_req_src2, cop_req_src3, vec_cop_req_opcode_word} = '0;
		{cop_req_src1_hi, cop_req_src2_hi, cop_req_src3_hi, vec_cop_src_a, vec_cop_src_b} = '0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		chk("req_rdy_off", 32'h0, {31'h0, cop_req_rdy});
		axi_rd({20'h0, ccp_pkg::REG_LAT});
		chk("lat_reset", ccp_pkg::LAT_RST, rd);
		axi_rd(32'h10);
		chk("unmapped_rd", {30'h0, ccp_pkg::RESP_SLVERR}, {30'h0, resp});
		axi_wr(32'h1000, 32'h1);
		chk("unmapped_wr", {30'h0, ccp_pkg::RESP_SLVERR}, {30'h0, resp});
		axi_wr({20'h0, ccp_pkg::REG_CTRL}, 32'h1);
		axi_rd({20'h0, ccp_pkg::REG_STAT});
		chk("stat_en", 32'h1, rd);
		cop_req_machine_priv <= 1'h1;
		for (i = 0; i < 4; i++) begin
			issue(32'(i) << ccp_pkg::OP_LSB, A, B, C);
			case (i)
				0: x = A + B;
				1: x = A - B;
				2: x = A ^ B;
				default: x = A * B + C;
			endcase
			chk("fast_lo", x[31:0], r);
			chk("fast_hi", x[63:32], rh);
		end
		issue(32'h1 << ccp_pkg::FPU_BIT, A, B, C);
		chk("fast_fault", 32'h1, {31'h0, f});
		cop_req_vld <= 1'h0;
		@(posedge aclk);
		issue((32'h1 << ccp_pkg::SLOW_BIT) | (32'h1 << ccp_pkg::OP_LSB), A, B, C);
		x = A - B;
		chk("slow_res", x[31:0], r);
		chk("slow_ok", 32'h0, {31'h0, f});
		axi_wr({20'h0, ccp_pkg::REG_LAT}, 32'h0);
		issue((32'h1 << ccp_pkg::SLOW_BIT) | (32'h1 << ccp_pkg::FPU_BIT), A, B, C);
		chk("slow_fault", 32'h1, {31'h0, f});
		// load, store, misaligned, reserved size, failed load
		for (i = 0; i < 5; i++) begin
			mem_err_req <= (i == 4);
			issue((32'h1 << ccp_pkg::MEM_BIT) | (32'h1 << ccp_pkg::SLOW_BIT)
				| (32'(MSZ[i]) << ccp_pkg::SIZE_LSB) | (32'(i == 1) << ccp_pkg::STORE_BIT),
				{32'h0, MADR[i]}, B, C);
			chk("mem_fault", {31'h0, i >= 2}, {31'h0, f});
			if (i == 0) chk("load_data", MADR[0] ^ 32'h5A5A_0000, r);
			if (i == 1) chk("store_data", B[31:0], last_wdata);
		end
		vec_cop_src_a <= {4{32'h8000_0001}};
		vec_cop_src_b <= {4{32'h8000_0003}};
		vec_cop_req_opcode_word <= 32'h1 << ccp_pkg::FPU_BIT;
		vec_cop_req_vld <= 1'h1;
		n = 0;
		do @(posedge aclk); while (vec_cop_req_rdy !== 1'h1 && ++n < 100);
		vec_cop_req_vld <= 1'h0;
		do @(posedge aclk); while (vec_cop_wb_vld !== 1'h1 && ++n < 100);
		vec_cop_wb_rdy <= 1'h1;
		@(posedge aclk);
		vec_cop_wb_rdy <= 1'h0;
		if (n >= 100) tmo();
		vsum = {1'h0, {4{32'h8000_0001}}} + {1'h0, {4{32'h8000_0003}}};
		chk("vec_lo", vsum[31:0], vec_cop_wb_data[31:0]);
		chk("vec_hi", vsum[127:96], vec_cop_wb_data[127:96]);
		chk("vec_flags", {30'h0, vsum[128], 1'h1}, {30'h0, vec_cop_wb_vxsat, vec_cop_wb_fflag});
		tally_and_finish();
	end
endmodule // testbench
`default_nettype wire
